// ===== core/dscd_decoder.sv
// Drive state command decoder: discrete input events and fieldbus control
// word drive the power-stage operating state machine.
// Assumes inputs synchronous-safe after internal synchronisers; parameter
// port accesses last one cycle.
`timescale 1ns/10ps
`default_nettype none
module dscd_decoder
  import dscd_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        digital_input_zero_in,
  input  wire logic        digital_input_one_in,
  input  wire logic        jog_pos_in,
  input  wire logic        jog_neg_in,
  input  wire logic        fieldbus_mode_in,
  input  wire logic        enable_assigned_in,
  input  wire logic        fault_reset_assigned_in,
  input  wire logic        dc_bus_ok_in,
  input  wire logic        fault_in,
  input  wire logic        fault_reaction_done_in,
  input  wire logic        standstill_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic [15:0]      reg_rdata_out,
  output logic             reg_rvalid_out,
  output logic [15:0]      drive_status_word_out,
  output logic [2:0]       state_out,
  output logic             power_stage_on_out,
  output logic             halt_out,
  output logic [3:0]       mode_bits_out,
  output logic             jog_mode_out,
  output logic             jog_dir_out,
  output logic             jog_start_out,
  output logic             jog_stop_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic dscd_cmd_type decode_cmd(input dscd_ctrl_word_type cw);
    dscd_cmd_type c;
    c = CMD_NONE;
    if (!cw.fault_reset) begin
      if (!cw.enable_voltage) begin
        c = CMD_DISABLE_VOLTAGE;
      end else if (!cw.quick_stop) begin
        c = CMD_QUICK_STOP;
      end else if (!cw.switch_on) begin
        c = CMD_SHUTDOWN;
      end else if (!cw.enable_operation) begin
        c = CMD_SWITCH_ON;
      end else begin
        c = CMD_ENABLE_OPERATION;
      end
    end
    return c;
  endfunction

  function automatic logic [6:0] state_bits(input dscd_state_type s);
    logic [6:0] b;
    b = 7'h00;
    unique case (s)
      ST_NOT_READY:          b = 7'h00;
      ST_SWITCH_ON_DISABLED: b = 7'h40;
      ST_READY_TO_SWITCH_ON: b = 7'h21;
      ST_SWITCHED_ON:        b = 7'h23;
      ST_OPERATION_ENABLED:  b = 7'h27;
      ST_QUICK_STOP_ACTIVE:  b = 7'h07;
      ST_FAULT_REACTION:     b = 7'h0F;
      ST_FAULT:              b = 7'h08;
    endcase
    return b;
  endfunction

  function automatic logic can_enable(input dscd_state_type s);
    return (s == ST_SWITCH_ON_DISABLED) || (s == ST_READY_TO_SWITCH_ON) ||
           (s == ST_SWITCHED_ON);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [DI_COUNT-1:0] raw_in;
  logic [DI_COUNT-1:0] rise;
  logic [DI_COUNT-1:0] fall;

  assign raw_in[DI_ENABLE]    = digital_input_zero_in;
  assign raw_in[DI_FAULT_RST] = digital_input_one_in;
  assign raw_in[DI_JOG_POS]   = jog_pos_in;
  assign raw_in[DI_JOG_NEG]   = jog_neg_in;

  genvar gi;
  generate
    for (gi = 0; gi < DI_COUNT; gi++) begin : g_sync
      dscd_edge_sync u_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .level_in   (raw_in[gi]),
        .level_out  (),
        .rise_out   (rise[gi]),
        .fall_out   (fall[gi])
      );
    end
  endgenerate

  logic enable_ok;
  logic fault_rst_ok;
  logic enable_rise;
  logic enable_fall;
  logic fault_rst_rise;

  assign enable_ok      = !fieldbus_mode_in || enable_assigned_in;
  assign fault_rst_ok   = !fieldbus_mode_in || fault_reset_assigned_in;
  assign enable_rise    = rise[DI_ENABLE] && enable_ok;
  assign enable_fall    = fall[DI_ENABLE] && enable_ok;
  assign fault_rst_rise = rise[DI_FAULT_RST] && fault_rst_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  dscd_state_type     state;
  dscd_state_type     next_state;
  dscd_ctrl_word_type ctrl_word;
  logic [15:0]        fault_opt;
  logic [15:0]        fault_opt_latched;
  logic [15:0]        status_word;
  logic               disable_pending;

  logic cw_wr;
  logic opt_wr;
  logic cw_act;
  dscd_ctrl_word_type cw_new;
  dscd_cmd_type       cmd;

  assign cw_wr  = reg_wr_in && (reg_addr_in == OFS_CONTROL_WORD);
  assign opt_wr = reg_wr_in && (reg_addr_in == OFS_FAULT_CLEAR_OPT);
  assign cw_new = dscd_ctrl_word_type'(reg_wdata_in);
  assign cw_act = cw_wr && fieldbus_mode_in;
  assign cmd    = decode_cmd(cw_new);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_word <= dscd_ctrl_word_type'(RST_CONTROL_WORD);
    end else if (cw_wr) begin
      ctrl_word          <= cw_new;
      ctrl_word.reserved <= 6'h00;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_opt <= RST_FAULT_CLEAR_OPT;
    end else if (opt_wr) begin
      fault_opt <= reg_wdata_in;
    end
  end

  logic entering_enable;
  assign entering_enable = (next_state == ST_OPERATION_ENABLED) &&
                           (state != ST_OPERATION_ENABLED) &&
                           (state != ST_QUICK_STOP_ACTIVE);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_opt_latched <= RST_FAULT_CLEAR_OPT;
    end else if (entering_enable) begin
      fault_opt_latched <= fault_opt;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out  <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          OFS_FAULT_CLEAR_OPT: reg_rdata_out <= fault_opt;
          OFS_CONTROL_WORD:    reg_rdata_out <= ctrl_word;
          OFS_STATUS_WORD:     reg_rdata_out <= status_word;
          default:             reg_rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State machine

  logic extra_clear;
  logic fault_clear;
  logic jog_rise;
  logic jog_fall;

  assign extra_clear = ((fault_opt_latched == OPT_CLEAR_FALLING) && enable_fall) ||
                       ((fault_opt_latched == OPT_CLEAR_RISING) && enable_rise);
  assign fault_clear = fault_rst_rise || extra_clear ||
                       (cw_act && cw_new.fault_reset && !ctrl_word.fault_reset);
  assign jog_rise    = rise[DI_JOG_POS] || rise[DI_JOG_NEG];
  assign jog_fall    = fall[DI_JOG_POS] || fall[DI_JOG_NEG];

  always_comb begin
    next_state = state;
    if (state == ST_NOT_READY) begin
      next_state = ST_SWITCH_ON_DISABLED;
    end else if (fault_in && state != ST_FAULT && state != ST_FAULT_REACTION) begin
      next_state = ST_FAULT_REACTION;
    end else if (state == ST_FAULT_REACTION) begin
      if (fault_reaction_done_in) next_state = ST_FAULT;
    end else if (state == ST_FAULT) begin
      if (fault_clear) next_state = ST_SWITCH_ON_DISABLED;
    end else if (state == ST_QUICK_STOP_ACTIVE && standstill_in && !cw_act) begin
      next_state = ST_SWITCH_ON_DISABLED;
    end else if (enable_fall && state != ST_SWITCH_ON_DISABLED) begin
      next_state = ST_SWITCH_ON_DISABLED;
    end else if (disable_pending && standstill_in) begin
      next_state = ST_SWITCH_ON_DISABLED;
    end else if ((enable_rise || jog_rise) && can_enable(state) && dc_bus_ok_in) begin
      next_state = ST_OPERATION_ENABLED;
    end else if (cw_act) begin
      unique case (cmd)
        CMD_SHUTDOWN: begin
          if (state == ST_SWITCH_ON_DISABLED) begin
            if (dc_bus_ok_in) next_state = ST_READY_TO_SWITCH_ON;
          end else if (state == ST_SWITCHED_ON || state == ST_OPERATION_ENABLED) begin
            next_state = ST_READY_TO_SWITCH_ON;
          end
        end
        CMD_SWITCH_ON: begin
          if (state == ST_READY_TO_SWITCH_ON || state == ST_OPERATION_ENABLED) begin
            next_state = ST_SWITCHED_ON;
          end
        end
        CMD_DISABLE_VOLTAGE: begin
          next_state = ST_SWITCH_ON_DISABLED;
        end
        CMD_QUICK_STOP: begin
          if (state == ST_OPERATION_ENABLED) begin
            next_state = ST_QUICK_STOP_ACTIVE;
          end else begin
            next_state = ST_SWITCH_ON_DISABLED;
          end
        end
        CMD_ENABLE_OPERATION: begin
          if (state == ST_SWITCHED_ON || state == ST_QUICK_STOP_ACTIVE) begin
            next_state = ST_OPERATION_ENABLED;
          end
        end
        CMD_NONE: next_state = state;
        default:  next_state = state;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_NOT_READY;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jog control

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      jog_mode_out    <= 1'b0;
      jog_dir_out     <= 1'b0;
      jog_start_out   <= 1'b0;
      jog_stop_out    <= 1'b0;
      disable_pending <= 1'b0;
    end else begin
      jog_start_out <= 1'b0;
      jog_stop_out  <= 1'b0;
      if (jog_rise && can_enable(state) && next_state == ST_OPERATION_ENABLED) begin
        jog_mode_out  <= 1'b1;
        jog_dir_out   <= rise[DI_JOG_POS];
        jog_start_out <= 1'b1;
      end else if (jog_fall && jog_mode_out) begin
        jog_stop_out    <= 1'b1;
        disable_pending <= 1'b1;
      end else if (next_state != ST_OPERATION_ENABLED) begin
        jog_mode_out    <= 1'b0;
        disable_pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_word <= 16'h0000;
    end else begin
      status_word               <= {9'h000, state_bits(next_state)};
      status_word[SW_DCOK_BIT]  <= dc_bus_ok_in;
      status_word[SW_HALT_BIT]  <= cw_wr ? cw_new.halt : ctrl_word.halt;
    end
  end

  assign halt_out              = ctrl_word.halt;
  assign mode_bits_out         = {ctrl_word.mode_bit9, ctrl_word.mode_bits};
  assign drive_status_word_out = status_word;
  assign state_out             = state;
  assign power_stage_on_out    = (state == ST_OPERATION_ENABLED) ||
                                 (state == ST_QUICK_STOP_ACTIVE) ||
                                 (state == ST_FAULT_REACTION);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic di_quiet;
  assign di_quiet = !fault_in && !enable_fall && !jog_rise && !disable_pending;

  a_enable_rise_op: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_SWITCHED_ON && enable_rise && dc_bus_ok_in && !fault_in
      |=> state == ST_OPERATION_ENABLED) else $error("enable rise did not enable");
  a_enable_fall_off: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_OPERATION_ENABLED && enable_fall && !fault_in
      |=> state == ST_SWITCH_ON_DISABLED) else $error("enable fall did not disable");
  a_option_latch_time: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $changed(fault_opt_latched) |-> state == ST_OPERATION_ENABLED &&
      $past(state) != ST_OPERATION_ENABLED) else $error("option latched off enable");
  a_fault_reset_in: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_FAULT && fault_rst_rise |=> state == ST_SWITCH_ON_DISABLED)
    else $error("fault reset input ignored");
  a_jog_pos_start: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    rise[DI_JOG_POS] && !rise[DI_JOG_NEG] && state == ST_SWITCH_ON_DISABLED &&
      dc_bus_ok_in && !fault_in && !enable_fall
      |=> jog_start_out && jog_dir_out && state == ST_OPERATION_ENABLED)
    else $error("positive jog did not start");
  a_jog_stop_pulse: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    jog_fall && jog_mode_out && !jog_rise |=> jog_stop_out && disable_pending)
    else $error("jog stop not issued");
  a_unassigned_enable: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_SWITCHED_ON && fieldbus_mode_in && !enable_assigned_in &&
      !cw_wr && di_quiet |=> state == ST_SWITCHED_ON)
    else $error("unassigned enable acted");
  a_shutdown_cmd: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_SWITCHED_ON && cw_act && cmd == CMD_SHUTDOWN && di_quiet &&
      !enable_rise |=> state == ST_READY_TO_SWITCH_ON)
    else $error("shutdown not decoded");
  a_cw_fault_edge: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_FAULT && cw_act && cw_new.fault_reset && !ctrl_word.fault_reset
      |=> state == ST_SWITCH_ON_DISABLED) else $error("fault reset edge ignored");
  a_fault_status: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_FAULT ##1 state == ST_FAULT
      |-> {status_word[SW_SODIS_BIT:SW_QSTOP_BIT], status_word[SW_FAULT_BIT:0]} == 6'h08)
    else $error("fault status wrong");
  a_dc_bus_block: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_SWITCH_ON_DISABLED && !dc_bus_ok_in
      |=> state != ST_READY_TO_SWITCH_ON) else $error("ready without bus voltage");
  a_halt_follows: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    cw_wr |=> halt_out == $past(reg_wdata_in[SW_HALT_BIT]) ##1 status_word[SW_HALT_BIT] ==
      halt_out) else $error("halt not taken");
  a_undefined_hold: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_READY_TO_SWITCH_ON && cw_act &&
      (cmd == CMD_NONE || cmd == CMD_ENABLE_OPERATION) && di_quiet && !enable_rise
      |=> $stable(state))
    else $error("undefined word changed state");

  c_reach_enabled: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_SWITCHED_ON ##1 state == ST_OPERATION_ENABLED);
  c_quick_stop: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_QUICK_STOP_ACTIVE ##[1:20] state == ST_SWITCH_ON_DISABLED);
  c_fault_cycle: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    state == ST_FAULT ##1 state == ST_SWITCH_ON_DISABLED);
  c_jog_stop: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    jog_stop_out ##[1:20] state == ST_SWITCH_ON_DISABLED);

endmodule
`default_nettype wire

// ===== core/dscd_edge_sync.sv
// Two-flop synchroniser with rising and falling edge pulses.
// Assumes the input is a slow discrete level.
`timescale 1ns/10ps
`default_nettype none
module dscd_edge_sync (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic level_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  logic sync_first;
  logic sync_second;
  logic prev;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      prev        <= 1'b0;
    end else begin
      sync_first  <= level_in;
      sync_second <= sync_first;
      prev        <= sync_second;
    end
  end

  assign level_out = sync_second;
  assign rise_out  = sync_second & ~prev;
  assign fall_out  = ~sync_second & prev;

endmodule
`default_nettype wire

// ===== core/dscd_pkg.sv
// Package for the drive state command decoder: register offsets, field layouts,
// reset values, state and command enumerations.
// Assumes a single clock domain and a simple parameter read/write port.
package dscd_pkg;

  // Parameter addresses
  localparam logic [15:0] OFS_FAULT_CLEAR_OPT = 16'h0568;
  localparam logic [15:0] OFS_CONTROL_WORD    = 16'h1B02;
  localparam logic [15:0] OFS_STATUS_WORD     = 16'h1B04;

  // Reset values
  localparam logic [15:0] RST_FAULT_CLEAR_OPT = 16'h0000;
  localparam logic [15:0] RST_CONTROL_WORD    = 16'h0000;

  // Enable-input fault clear option encodings
  localparam logic [15:0] OPT_CLEAR_OFF     = 16'h0000;
  localparam logic [15:0] OPT_CLEAR_FALLING = 16'h0001;
  localparam logic [15:0] OPT_CLEAR_RISING  = 16'h0002;

  // Status word bit positions
  localparam int unsigned SW_READY_BIT   = 0;
  localparam int unsigned SW_SWON_BIT    = 1;
  localparam int unsigned SW_OPEN_BIT    = 2;
  localparam int unsigned SW_FAULT_BIT   = 3;
  localparam int unsigned SW_DCOK_BIT    = 4;
  localparam int unsigned SW_QSTOP_BIT   = 5;
  localparam int unsigned SW_SODIS_BIT   = 6;
  localparam int unsigned SW_HALT_BIT    = 8;

  // Discrete input slots
  localparam int unsigned DI_ENABLE    = 0;
  localparam int unsigned DI_FAULT_RST = 1;
  localparam int unsigned DI_JOG_POS   = 2;
  localparam int unsigned DI_JOG_NEG   = 3;
  localparam int unsigned DI_COUNT     = 4;

  // Control word layout, bit 15 first
  typedef struct packed {
    logic [5:0] reserved;
    logic       mode_bit9;
    logic       halt;
    logic       fault_reset;
    logic [2:0] mode_bits;
    logic       enable_operation;
    logic       quick_stop;
    logic       enable_voltage;
    logic       switch_on;
  } dscd_ctrl_word_type;

  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_SWITCH_ON_DISABLED,
    ST_READY_TO_SWITCH_ON,
    ST_SWITCHED_ON,
    ST_OPERATION_ENABLED,
    ST_QUICK_STOP_ACTIVE,
    ST_FAULT_REACTION,
    ST_FAULT
  } dscd_state_type;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_SHUTDOWN,
    CMD_SWITCH_ON,
    CMD_DISABLE_VOLTAGE,
    CMD_QUICK_STOP,
    CMD_ENABLE_OPERATION
  } dscd_cmd_type;

endpackage

// ===== verif/dscd_decoder_tb_top.sv
// Testbench for the decoder: pin events and control word sequences.
// Assumes the host model drives the register port and discrete lines.
`timescale 1ns/10ps
`default_nettype none
module dscd_decoder_tb_top;
  import dscd_pkg::*;
  logic        mclk_in;
  logic        reset_n_in;
  logic        fb;
  logic        dc_ok;
  logic        flt;
  logic        flt_done;
  logic        still;
  logic [3:0]  pins;
  logic        wr;
  logic        rd;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] sw;
  logic [15:0] v;
  logic [2:0]  st;
  logic        halt;
  logic        jmode;
  logic        jdir;
  logic        vl;
  logic        rvld;
  logic        pwr;
  logic        asg;
  logic [3:0]  mbits;
  int          fail_count;
  int          samples_checked;
  logic [15:0] cws [16] = '{16'h7, 16'h6, 16'h7, 16'h6, 16'h7, 16'hF, 16'h7, 16'hF,
                            16'h0, 16'h6, 16'h2, 16'h6, 16'hF, 16'h7, 16'hF, 16'h2};
  logic [2:0]  sts [16] = '{1, 2, 3, 2, 3, 4, 3, 4, 1, 2, 1, 2, 2, 3, 4, 5};

  dscd_host_model i_host (.mclk_in(mclk_in), .rdata_in(rdata), .rvalid_in(rvld), .pins_out(pins),
    .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

  dscd_decoder i_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .digital_input_zero_in(pins[DI_ENABLE]), .digital_input_one_in(pins[DI_FAULT_RST]),
    .jog_pos_in(pins[DI_JOG_POS]), .jog_neg_in(pins[DI_JOG_NEG]),
    .fieldbus_mode_in(fb), .enable_assigned_in(asg), .fault_reset_assigned_in(asg),
    .dc_bus_ok_in(dc_ok), .fault_in(flt), .fault_reaction_done_in(flt_done),
    .standstill_in(still), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvld),
    .drive_status_word_out(sw), .state_out(st), .power_stage_on_out(pwr),
    .halt_out(halt), .mode_bits_out(mbits), .jog_mode_out(jmode), .jog_dir_out(jdir),
    .jog_start_out(), .jog_stop_out());

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Drive error through reaction into the fault state
  task automatic fault_go;
    @(negedge mclk_in);
    flt = 1'b1;
    repeat (2) @(negedge mclk_in);
    chk("status_fra", sw, 16'h001F);
    flt = 1'b0;
    flt_done = 1'b1;
    repeat (2) @(negedge mclk_in);
    flt_done = 1'b0;
    chk("status_fault", sw, 16'h0018);
  endtask

  initial begin
    fail_count = 0;
    samples_checked = 0;
    reset_n_in = 1'b0;
    {fb, flt, flt_done, still, asg} = 5'h00;
    dc_ok = 1'b1;
    repeat (5) @(negedge mclk_in);
    reset_n_in = 1'b1;
    i_host.rd(OFS_STATUS_WORD, v, vl);
    chk("status_sod", v, 16'h0050);
    chk("rvalid", 16'(vl), 16'd1);
    i_host.rd(OFS_FAULT_CLEAR_OPT, v, vl);
    chk("opt_reset", v, RST_FAULT_CLEAR_OPT);
    i_host.rd(16'h1234, v, vl);
    chk("unmapped", v, 16'h0000);
    i_host.pin(DI_ENABLE, 1);
    chk("state_en", 16'(st), 16'd4);
    chk("power_on", 16'(pwr), 16'd1);
    chk("status_open", sw, 16'h0037);
    i_host.pin(DI_ENABLE, 0);
    chk("state_dis", 16'(st), 16'd1);
    chk("power_off", 16'(pwr), 16'd0);
    for (int j = 0; j < 2; j++) begin
      i_host.pin(DI_JOG_POS + j, 1);
      chk("jog_state", 16'(st), 16'd4);
      chk("jog_mode", 16'(jmode), 16'd1);
      chk("jog_dir", 16'(jdir), 16'(1 - j));
      i_host.pin(DI_JOG_POS + j, 0);
      still = 1'b1;
      repeat (3) @(negedge mclk_in);
      still = 1'b0;
      chk("jog_off", 16'(st), 16'd1);
    end
    fault_go();
    i_host.pin(DI_FAULT_RST, 1);
    chk("pin_clear", 16'(st), 16'd1);
    i_host.pin(DI_FAULT_RST, 0);
    i_host.wr(OFS_FAULT_CLEAR_OPT, OPT_CLEAR_FALLING);
    i_host.pin(DI_ENABLE, 1);
    i_host.wr(OFS_FAULT_CLEAR_OPT, OPT_CLEAR_OFF);
    fault_go();
    i_host.pin(DI_ENABLE, 0);
    chk("clear_fall", 16'(st), 16'd1);
    i_host.wr(OFS_FAULT_CLEAR_OPT, OPT_CLEAR_RISING);
    i_host.pin(DI_ENABLE, 1);
    i_host.pin(DI_ENABLE, 0);
    fault_go();
    i_host.pin(DI_ENABLE, 1);
    chk("clear_rise", 16'(st), 16'd1);
    i_host.pin(DI_ENABLE, 0);
    fb = 1'b1;
    i_host.pin(DI_ENABLE, 1);
    chk("fb_unassigned", 16'(st), 16'd1);
    i_host.pin(DI_ENABLE, 0);
    asg = 1'b1;
    i_host.pin(DI_ENABLE, 1);
    chk("fb_assigned", 16'(st), 16'd4);
    i_host.pin(DI_ENABLE, 0);
    asg = 1'b0;
    dc_ok = 1'b0;
    i_host.wr(OFS_CONTROL_WORD, 16'h0006);
    chk("dc_block", sw, 16'h0040);
    dc_ok = 1'b1;
    for (int k = 0; k < 16; k++) begin
      i_host.wr(OFS_CONTROL_WORD, cws[k]);
      chk("cw_state", 16'(st), 16'(sts[k]));
    end
    still = 1'b1;
    repeat (3) @(negedge mclk_in);
    still = 1'b0;
    chk("qs_end", 16'(st), 16'd1);
    i_host.wr(OFS_CONTROL_WORD, 16'h0370);
    chk("halt", 16'(halt), 16'd1);
    chk("mode_bits", 16'(mbits), 16'h000F);
    i_host.wr(OFS_CONTROL_WORD, 16'hFC06, 1);
    i_host.rd(OFS_CONTROL_WORD, v, vl);
    chk("cw_reserved", v, 16'h0006);
    fault_go();
    i_host.wr(OFS_CONTROL_WORD, 16'h0080);
    chk("cw_clear", 16'(st), 16'd1);
    fault_go();
    i_host.wr(OFS_CONTROL_WORD, 16'h0080);
    chk("cw_no_edge", 16'(st), 16'd7);
    i_host.pin(DI_FAULT_RST, 1);
    chk("fr_unassigned", 16'(st), 16'd7);
    i_host.pin(DI_FAULT_RST, 0);
    asg = 1'b1;
    i_host.pin(DI_FAULT_RST, 1);
    chk("fr_assigned", 16'(st), 16'd1);
    close_out();
  end

  initial begin
    #500us;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire

// ===== verif/dscd_host_model.sv
// Host controller and discrete input lines that face the decoder.
// Assumes one clock; every line changes on a falling edge.
`timescale 1ns/10ps
`default_nettype none
module dscd_host_model
  import dscd_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic [3:0]       pins_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [15:0]      addr_out,
  output logic [15:0]      wdata_out
);
  initial begin
    pins_out = 4'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input bit keep = 0);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = (a == OFS_CONTROL_WORD && !keep) ? (d & 16'h03FF) : d;
    wr_out = 1'b1;
    @(negedge mclk_in);
    wr_out = 1'b0;
  endtask

  // Data and valid are taken in the cycle after the strobe, while they stand
  task automatic rd(input logic [15:0] a, output logic [15:0] v, output logic ok);
    @(negedge mclk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge mclk_in);
    rd_out = 1'b0;
    ok = rvalid_in;
    v = rdata_in;
  endtask

  // Level change, then time for sync and state update
  task automatic pin(input int i, input logic val);
    @(negedge mclk_in);
    pins_out[i] = val;
    repeat (6) @(negedge mclk_in);
  endtask
endmodule
`default_nettype wire
